// ==== inc/bcs_pkg.sv ====
// bcs_pkg: constants, register map and state encoding for the charge sequencer
// assumes: one 125 MHz clock, registers reached over avalon-mm with 32-bit data
`default_nettype none
package bcs_pkg;
	// register byte offsets
	localparam logic [3:0] CTRL_OFFS = 4'h0;
	localparam logic [3:0] INPUT_OFFS = 4'h4;
	localparam logic [3:0] STATE_OFFS = 4'h8;
	localparam logic [3:0] TIMER_OFFS = 4'hC;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_OSC_DIV_LSB = 8;
	localparam int CTRL_OSC_DIV_W = 20;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// input register fields (comparator and enable levels as seen after the two-flop synchroniser)
	localparam int IN_BAT_BIT = 0;
	localparam int IN_EOC_BIT = 1;
	localparam int IN_RCH_BIT = 2;
	localparam int IN_TEMP_BIT = 3;
	localparam int IN_EN_BIT = 4;
	// state register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_FULL_BIT = 4;
	localparam int ST_CHG_BIT = 5;
	localparam int ST_STATUS_BIT = 6;
	localparam int ST_FAULT_BIT = 7;
	localparam int ST_TEMP_BIT = 8;
	// timing: oscillator period 3.0 ms in microseconds
	localparam int OSC_PERIOD_US = 3000;
	localparam int CLK_MHZ = 125;
	localparam int OSC_PERIOD_CYC = OSC_PERIOD_US * CLK_MHZ;
	// safety timer length as a power of two of oscillator periods
	localparam int TIMEOUT_LOG2 = 22;
	localparam int TRICKLE_SHIFT = 3;
	localparam int TIMER_W = 23;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// states, gray along disabled-trickle-fast-complete-inhibit
	typedef enum logic [2:0] {
		ST_DISABLED = 3'h0,
		ST_TRICKLE = 3'h1,
		ST_FAST = 3'h3,
		ST_COMPLETE = 3'h2,
		ST_INHIBIT = 3'h6,
		ST_TIMEOUT = 3'h4
	} bcs_state_t;
endpackage
`default_nettype wire

// ==== hw/bcs_sync.sv ====
// bcs_sync: two-flop synchroniser for a vector of asynchronous levels
// assumes: inputs are slow levels from comparators or pins
`timescale 1ns/1ns
`default_nettype none
module bcs_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic [WIDTH-1:0] d, // asynchronous inputs
	output logic [WIDTH-1:0] q // synchronised outputs
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== hw/bcs_charge_seq.sv ====
// bcs_charge_seq: charge-cycle sequencer with safety timer and open-drain status and fault pins
// assumes: comparator levels arrive asynchronously; avalon-mm master on clk; arst_n is power-on reset
`timescale 1ns/1ns
`default_nettype none
module bcs_charge_seq #(
	parameter int OSC_DIV = bcs_pkg::OSC_PERIOD_CYC, // clk cycles per oscillator period
	parameter int TIMEOUT_LOG2 = bcs_pkg::TIMEOUT_LOG2 // fast limit as log2 of periods
) (
	input wire logic clk, // 125 MHz clock
	input wire logic arst_n, // power-on reset, active low
	input wire logic bat_above_in, // battery above trickle threshold
	input wire logic eoc_low_in, // current at or below one tenth of full
	input wire logic rch_low_in, // battery 150 mV under regulation_voltage
	input wire logic temp_ok_in, // thermistor_voltage inside window
	input wire logic en_pin_in, // enable pin level from pad
	input wire logic en_pin_oe_in, // high while something drives the enable pin
	input wire logic [31:0] avs_address, // avalon byte address
	input wire logic avs_read, // avalon read
	input wire logic avs_write, // avalon write
	input wire logic [31:0] avs_writedata, // avalon write data
	input wire logic [3:0] avs_byteenable, // avalon byte enables
	output logic [31:0] avs_readdata, // avalon read data
	output logic avs_waitrequest, // avalon wait request
	output logic charge_on, // charger current source on
	output logic full_current, // full current selected, else one tenth
	output logic status_o, // status pin output level
	output logic status_oe, // status pin output enable (pull low)
	output logic fault_o, // fault pin output level
	output logic fault_oe // fault pin output enable (pull low)
);
	// ==========================================================
	// input synchronisers
	logic [4:0] raw_in;
	logic [4:0] sync_in;
	wire en_pad = en_pin_oe_in ? en_pin_in : 1'b1;
	assign raw_in = {en_pad, temp_ok_in, rch_low_in, eoc_low_in, bat_above_in};
	// enable resets deasserted: a pin held low after reset must not start a brief trickle
	// before the synchroniser has settled; an undriven pin still enables two edges later
	bcs_sync #(.WIDTH(5), .INIT(5'(1 << bcs_pkg::IN_TEMP_BIT))) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d(raw_in),
		.q(sync_in)
	);

	// ==========================================================
	// oscillator tick divider
	logic [31:0] div_reg;
	logic [31:0] div_next;
	logic tick_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	wire [31:0] sw_div = {12'h000, ctrl_reg[bcs_pkg::CTRL_OSC_DIV_LSB +: bcs_pkg::CTRL_OSC_DIV_W]};
	wire [31:0] div_limit = (sw_div != 32'h0) ? sw_div : 32'(OSC_DIV);
	wire div_wrap = (div_reg + 32'h1) >= div_limit;
	assign div_next = div_wrap ? 32'h0 : div_reg + 32'h1;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= div_wrap;
		end
	end

	// ==========================================================
	// comparator resampling on the oscillator tick
	logic bat_reg, eoc_reg, rch_reg, temp_reg;
	logic eoc_prev_reg, rch_prev_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bat_reg <= 1'b0;
			eoc_reg <= 1'b0;
			rch_reg <= 1'b0;
			temp_reg <= 1'b1;
			eoc_prev_reg <= 1'b0;
			rch_prev_reg <= 1'b0;
		end else if (tick_reg) begin
			bat_reg <= sync_in[bcs_pkg::IN_BAT_BIT];
			eoc_reg <= sync_in[bcs_pkg::IN_EOC_BIT];
			rch_reg <= sync_in[bcs_pkg::IN_RCH_BIT];
			temp_reg <= sync_in[bcs_pkg::IN_TEMP_BIT];
			eoc_prev_reg <= eoc_reg;
			rch_prev_reg <= rch_reg;
		end
	end
	// a level seen on two successive ticks has lasted longer than one period
	wire eoc_qual = eoc_reg & eoc_prev_reg & sync_in[bcs_pkg::IN_EOC_BIT];
	wire rch_qual = rch_reg & rch_prev_reg & sync_in[bcs_pkg::IN_RCH_BIT];

	// ==========================================================
	// enable: software gate and pin, with edge memory for fault clear
	wire en_sw = ctrl_reg[bcs_pkg::CTRL_EN_BIT];
	wire en_pin_now = sync_in[bcs_pkg::IN_EN_BIT];
	wire en_now = en_pin_now & ~en_sw;
	// fall memory follows the pin alone, so the software gate cannot clear a timeout
	logic en_prev_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_prev_reg <= 1'b0;
		end else begin
			en_prev_reg <= en_pin_now;
		end
	end

	// ==========================================================
	// safety timer
	function automatic logic [bcs_pkg::TIMER_W-1:0] limit_of(input int log2);
		limit_of = bcs_pkg::TIMER_W'(1) << log2;
	endfunction
	localparam logic [bcs_pkg::TIMER_W-1:0] FAST_LIMIT = limit_of(TIMEOUT_LOG2);
	localparam logic [bcs_pkg::TIMER_W-1:0] TRICKLE_LIMIT = limit_of(TIMEOUT_LOG2 - bcs_pkg::TRICKLE_SHIFT);
	logic [bcs_pkg::TIMER_W-1:0] timer_reg;
	logic [bcs_pkg::TIMER_W-1:0] timer_next;
	bcs_pkg::bcs_state_t state_reg;
	bcs_pkg::bcs_state_t state_next;
	wire timer_clear = (state_next != state_reg) &&
		(state_next == bcs_pkg::ST_TRICKLE || state_next == bcs_pkg::ST_FAST);
	wire timer_run = tick_reg && temp_reg && timer_reg != FAST_LIMIT &&
		(state_reg == bcs_pkg::ST_TRICKLE || state_reg == bcs_pkg::ST_FAST ||
		state_reg == bcs_pkg::ST_COMPLETE);
	assign timer_next = timer_clear ? '0 : (timer_run ? timer_reg + 1'b1 : timer_reg);
	wire trickle_expired = timer_reg >= TRICKLE_LIMIT;
	wire fast_expired = timer_reg >= FAST_LIMIT;

	// ==========================================================
	// charge state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bcs_pkg::ST_DISABLED: begin
				if (en_now) begin
					state_next = bcs_pkg::ST_TRICKLE;
				end
			end
			bcs_pkg::ST_TRICKLE: begin
				if (!en_now) begin
					state_next = bcs_pkg::ST_DISABLED;
				end else if (trickle_expired) begin
					state_next = bcs_pkg::ST_TIMEOUT;
				end else if (bat_reg) begin
					state_next = bcs_pkg::ST_FAST;
				end
			end
			bcs_pkg::ST_FAST: begin
				if (!en_now) begin
					state_next = bcs_pkg::ST_DISABLED;
				end else if (fast_expired) begin
					state_next = bcs_pkg::ST_TIMEOUT;
				end else if (eoc_qual) begin
					state_next = bcs_pkg::ST_COMPLETE;
				end
			end
			bcs_pkg::ST_COMPLETE: begin
				if (!en_now) begin
					state_next = bcs_pkg::ST_DISABLED;
				end else if (fast_expired) begin
					state_next = bcs_pkg::ST_INHIBIT;
				end
			end
			bcs_pkg::ST_INHIBIT: begin
				if (!en_now) begin
					state_next = bcs_pkg::ST_DISABLED;
				end else if (rch_qual) begin
					state_next = bcs_pkg::ST_TRICKLE;
				end
			end
			bcs_pkg::ST_TIMEOUT: begin
				// only an enable fall leaves here; a power cycle is the reset
				if (en_prev_reg && !en_pin_now) begin
					state_next = bcs_pkg::ST_DISABLED;
				end
			end
			default: begin
				state_next = bcs_pkg::ST_DISABLED;
			end
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= bcs_pkg::ST_DISABLED;
			timer_reg <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
		end
	end

	// ==========================================================
	// charger and pin outputs
	wire charging_state = state_next == bcs_pkg::ST_TRICKLE || state_next == bcs_pkg::ST_FAST ||
		state_next == bcs_pkg::ST_COMPLETE;
	wire charge_next = charging_state & temp_reg;
	wire full_next = charge_next & (state_next != bcs_pkg::ST_TRICKLE) & bat_reg;
	// status pulls low only while charging and before eoc
	wire status_low_next = state_next == bcs_pkg::ST_TRICKLE || state_next == bcs_pkg::ST_FAST;
	wire temp_fault = charging_state & ~temp_reg;
	wire fault_low_next = temp_fault | (state_next == bcs_pkg::ST_TIMEOUT);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			charge_on <= 1'b0;
			full_current <= 1'b0;
			status_oe <= 1'b0;
			fault_oe <= 1'b0;
		end else begin
			charge_on <= charge_next;
			full_current <= full_next;
			status_oe <= status_low_next;
			fault_oe <= fault_low_next;
		end
	end
	// open-drain: driven level is always low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_o <= 1'b0;
			fault_o <= 1'b0;
		end else begin
			status_o <= 1'b0;
			fault_o <= 1'b0;
		end
	end

	// ==========================================================
	// avalon-mm slave: one wait cycle, answer on the second edge
	wire [3:0] offs = avs_address[3:0];
	wire addr_hi_zero = avs_address[31:4] == 28'h0;
	wire sel_ctrl = addr_hi_zero && offs == bcs_pkg::CTRL_OFFS;
	wire sel_in = addr_hi_zero && offs == bcs_pkg::INPUT_OFFS;
	wire sel_state = addr_hi_zero && offs == bcs_pkg::STATE_OFFS;
	wire sel_timer = addr_hi_zero && offs == bcs_pkg::TIMER_OFFS;
	logic ack_reg;
	wire req = (avs_read | avs_write) & ~ack_reg;
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge_be = r;
	endfunction
	assign ctrl_next = (req && avs_write && sel_ctrl) ?
		merge_be(ctrl_reg, avs_writedata, avs_byteenable) : ctrl_reg;
	wire [31:0] in_word = {27'h0, sync_in};
	wire [31:0] state_word = {23'h0, temp_fault, fault_oe, status_oe, charge_on, full_current,
		1'b0, state_reg};
	wire [31:0] timer_word = {9'h0, timer_reg};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_reg : sel_in ? in_word : sel_state ? state_word :
		sel_timer ? timer_word : bcs_pkg::UNMAPPED_DATA;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= bcs_pkg::CTRL_RESET;
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0;
			avs_waitrequest <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			ack_reg <= req;
			avs_waitrequest <= ~req;
			if (req && avs_read) begin
				avs_readdata <= rd_mux;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/bcs_batt_model.sv ====
// cell and thermistor model on the far side of the charge sequencer
// assumes: charge_on and full_current are levels on clk
`timescale 1ns/1ns
`default_nettype none
module bcs_batt_model (
	input wire logic clk, // clock
	input wire logic charge_on, // current source on
	input wire logic full_current, // full or tenth current
	input wire logic drain, // load pulls the cell down hard
	input wire logic hot, // thermistor out of window
	output logic bat_above_in, // above trickle level
	output logic eoc_low_in, // current has tapered
	output logic rch_low_in, // sagged below recharge level
	output logic temp_ok_in // thermistor in window
);
	// ==========
	// charge level
	int lvl = 0;
	int n;
	always @(posedge clk) begin
		n = lvl + (charge_on ? (full_current ? 8 : 2) : 0) - (drain ? 20 : 0);
		lvl <= (n < 0) ? 0 : ((n > 120) ? 120 : n);
	end
	assign bat_above_in = lvl >= 20;
	assign eoc_low_in = lvl >= 100;
	assign rch_low_in = lvl < 85;
	assign temp_ok_in = !hot;
endmodule
`default_nettype wire

// ==== sim/bcs_charge_seq_sva.sv ====
// checker for the charge sequencer pins and bus handshake
// assumes: bound to bcs_charge_seq, one clock
`timescale 1ns/1ns
`default_nettype none
module bcs_charge_seq_sva #(
	parameter int OSC_DIV = 4,
	parameter int TIMEOUT_LOG2 = 6
) (
	input wire logic clk, // clock
	input wire logic arst_n, // reset
	input wire logic temp_ok_in, // thermistor ok
	input wire logic en_pin_in, // enable level
	input wire logic en_pin_oe_in, // enable driven
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic avs_waitrequest, // wait
	input wire logic charge_on, // source on
	input wire logic full_current, // full level
	input wire logic status_o, // status level
	input wire logic status_oe, // status pulled
	input wire logic fault_o, // fault level
	input wire logic fault_oe // fault pulled
);
	// ==========
	// helpers: slack covers sync flops and tick phase
	localparam int LIM_T = (OSC_DIV << (TIMEOUT_LOG2 - 3)) + 2 * OSC_DIV + 4;
	localparam int LIM_F = (OSC_DIV << TIMEOUT_LOG2) + 2 * OSC_DIV + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	int trk_cnt, fst_cnt, hot_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trk_cnt <= 0;
			fst_cnt <= 0;
			hot_cnt <= 0;
		end else begin
			trk_cnt <= (charge_on && !full_current) ? trk_cnt + 1 : 0;
			fst_cnt <= (charge_on && full_current) ? fst_cnt + 1 : 0;
			hot_cnt <= temp_ok_in ? 0 : hot_cnt + 1;
		end
	end
	a_open_drain: assert property (
		!status_o && !fault_o) else $error("open-drain level driven high");
	a_enable_stops: assert property (
		(!(en_pin_in || !en_pin_oe_in))[*6] |-> !charge_on) else $error("charging while disabled");
	a_temp_stops: assert property (
		hot_cnt >= 12 |-> !charge_on) else $error("charging out of temperature window");
	a_fault_no_charge: assert property (
		fault_oe |-> !charge_on) else $error("charging during fault");
	a_trickle_status: assert property (
		charge_on && !full_current |-> ##0 status_oe) else $error("trickle without status low");
	a_trickle_limit: assert property (
		trk_cnt <= LIM_T) else $error("trickle outlasted its limit");
	a_fast_limit: assert property (
		fst_cnt <= LIM_F) else $error("fast charge outlasted its limit");
	a_bus_answer: assert property ( // bus handshake
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
	a_wait_single: assert property ( // bus handshake
		!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
	c_complete: cover property (charge_on && full_current && !status_oe);
	c_fault: cover property (fault_oe);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind bcs_charge_seq bcs_charge_seq_sva #(.OSC_DIV(OSC_DIV), .TIMEOUT_LOG2(TIMEOUT_LOG2)) u_sva (.clk(clk),
	.arst_n(arst_n), .temp_ok_in(temp_ok_in), .en_pin_in(en_pin_in), .en_pin_oe_in(en_pin_oe_in),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .charge_on(charge_on),
	.full_current(full_current), .status_o(status_o), .status_oe(status_oe), .fault_o(fault_o),
	.fault_oe(fault_oe));
`default_nettype wire

// ==== sim/test_bcs_charge_seq.sv ====
// bench for the charge sequencer: register rows, then a full charge cycle
// assumes: battery model in bcs_batt_model, short divider and timer
`timescale 1ns/1ns
`default_nettype none
module test_bcs_charge_seq;
	typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [31:0] e;} bcs_row_t;
	logic clk = 0, arst_n = 0, en_pin_in = 0, en_pin_oe_in = 0, drain = 1, hot = 0;
	logic bat, eoc, rch, tok, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [31:0] avs_address = 0, avs_writedata = 0, avs_readdata, q;
	logic charge_on, full_current, status_o, status_oe, fault_o, fault_oe;
	int n_fail = 0, samples_checked = 0;
	bcs_row_t rows [7];
	always #4 clk = ~clk;
	bcs_charge_seq #(.OSC_DIV(4), .TIMEOUT_LOG2(6)) dut_u (.clk(clk), .arst_n(arst_n), .bat_above_in(bat),
		.eoc_low_in(eoc), .rch_low_in(rch), .temp_ok_in(tok), .en_pin_in(en_pin_in), .en_pin_oe_in(en_pin_oe_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.charge_on(charge_on), .full_current(full_current), .status_o(status_o), .status_oe(status_oe),
		.fault_o(fault_o), .fault_oe(fault_oe));
	bcs_batt_model batt_u (.clk(clk), .charge_on(charge_on), .full_current(full_current), .drain(drain),
		.hot(hot), .bat_above_in(bat), .eoc_low_in(eoc), .rch_low_in(rch), .temp_ok_in(tok));
	// ==========
	// shared tasks
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		n_fail++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		if (i == 20) fail("bus answer missing");
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// waits for {charge_on, full_current, status_oe, fault_oe} under a mask
	task automatic expect_out(input logic [3:0] e, input logic [3:0] m, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge clk);
			if ((({charge_on, full_current, status_oe, fault_oe} ^ e) & m) === 4'h0) break;
		end
		samples_checked++;
		if (i == lim) fail($sformatf("outputs %b want %b", {charge_on, full_current, status_oe, fault_oe}, e));
		@(posedge clk);
	endtask
	// ==========
	// main sequence
	initial begin
		rows = '{'{1'b0, 32'h0, 32'h0, 32'h0}, '{1'b1, 32'h0, 32'h101, 32'h0}, '{1'b0, 32'h0, 32'h0, 32'h101},
			'{1'b1, 32'h40, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 32'h40, 32'h0, 32'h0},
			'{1'b1, 32'h0, 32'h0, 32'h0}, '{1'b0, 32'h0, 32'h0, 32'h0}};
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		expect_out(4'b1010, 4'b1111, 20);
		foreach (rows[k]) begin
			bus(rows[k].wr, rows[k].a, rows[k].d);
			samples_checked++;
			if (!rows[k].wr && q !== rows[k].e) fail("register readback");
		end
		$display("test registers done");
		drain <= 1'b0;
		expect_out(4'b1010, 4'b1111, 40);
		expect_out(4'b1110, 4'b1111, 60);
		expect_out(4'b1100, 4'b1111, 60);
		repeat (150) @(posedge clk);
		expect_out(4'b1000, 4'b1000, 1);
		expect_out(4'b0000, 4'b1011, 150);
		$display("test charge cycle done");
		drain <= 1'b1;
		expect_out(4'b1010, 4'b1111, 80);
		expect_out(4'b0001, 4'b1001, 60);
		drain <= 1'b0;
		repeat (40) @(posedge clk);
		expect_out(4'b0001, 4'b1001, 1);
		en_pin_oe_in <= 1'b1;
		expect_out(4'b0000, 4'b1001, 20);
		en_pin_in <= 1'b1;
		expect_out(4'b1010, 4'b1111, 20);
		$display("test timeout done");
		hot <= 1'b1;
		expect_out(4'b0001, 4'b1001, 20);
		hot <= 1'b0;
		expect_out(4'b1000, 4'b1001, 20);
		$display("test temperature done");
		en_pin_in <= 1'b0;
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		for (int j = 0; j < 20; j++) begin
			@(negedge clk);
			samples_checked++;
			if (charge_on !== 1'b0) fail("charging after reset with enable low");
		end
		@(posedge clk);
		expect_out(4'b0000, 4'b1001, 1);
		$display("test reset disabled done");
		end_sim;
	end
	initial begin
		#40000;
		fail("watchdog expired");
		end_sim;
	end
endmodule
`default_nettype wire
